//--- pbs_seq.sv
// push button power sequencer: debounce, blanking, kill handshake and lockout
`timescale 1ns/1ps
`default_nettype none
module pbs_seq #(
    parameter bit                           EN_HIGH_TRUE = 1'b1,
    parameter logic [pbs_pkg::CNT_W-1:0]    TICK_DIV     = pbs_pkg::CNT_W'(pbs_pkg::TICK_DIV),
    parameter logic [pbs_pkg::CNT_W-1:0]    KILL_QUAL    = pbs_pkg::CNT_W'(pbs_pkg::KILL_QUAL_CYC)
) (
    input  wire logic                       CLK_IN,                 // 200 MHz clock
    input  wire logic                       RST_IN,                 // sync reset, active high
    input  wire logic                       PUSH_BUTTON_N_IN,       // button pin, low = pressed
    input  wire logic                       POWER_KILL_N_IN,        // host kill pin, low = kill
    input  wire logic [pbs_pkg::EXT_W-1:0]  OFF_DELAY_EXTEND_IN,    // extra off debounce ticks
    input  wire logic [pbs_pkg::EXT_W-1:0]  KILL_DELAY_EXTEND_IN,   // extra kill timeout ticks
    output logic                            POWER_ENABLE_OUT,       // system power enable
    output logic                            SHUTDOWN_REQUEST_N_OUT  // low asks host to shut down
);
    localparam int unsigned N_PINS   = 2;        // button and kill pins
    localparam int unsigned PIN_PB   = 0;
    localparam int unsigned PIN_KILL = 1;
    localparam logic        PIN_IDLE = 1'b1;     // released button, live host

    pbs_pkg::pbs_state_t        state;
    pbs_pkg::pbs_state_t        next_state;
    logic [N_PINS-1:0]          pin_raw;
    wire  [N_PINS-1:0]          pin_sync;
    logic                       pb_low;
    logic                       kill_low;
    logic [pbs_pkg::CNT_W-1:0]  div_cnt;
    logic [pbs_pkg::CNT_W-1:0]  next_div_cnt;
    logic                       div_wrap;
    logic                       tick;
    logic [pbs_pkg::CNT_W-1:0]  kq_cnt;
    logic                       kq_done;
    logic                       kill_q;
    pbs_pkg::pbs_ext_t          ext;
    logic [pbs_pkg::CNT_W-1:0]  off_lim;
    logic [pbs_pkg::CNT_W-1:0]  kill_lim;
    logic [pbs_pkg::CNT_W-1:0]  tmr;
    logic [pbs_pkg::CNT_W-1:0]  next_tmr;
    logic                       tmr_clear;
    logic                       pb_restart;
    logic                       in_run_rel;
    logic                       in_run;
    logic                       on;
    logic                       shut;

    // pins pass two flip-flops; reset to the idle level so no false press follows reset
    assign pin_raw = {POWER_KILL_N_IN, PUSH_BUTTON_N_IN};

    for (genvar p = 0; p < N_PINS; p++) begin : g_sync
        logic meta;
        logic held;

        always_ff @(posedge CLK_IN) begin
            if (RST_IN) begin
                meta <= PIN_IDLE;
                held <= PIN_IDLE;
            end else begin
                meta <= pin_raw[p];
                held <= meta;
            end
        end

        assign pin_sync[p] = held;
    end

    assign pb_low   = ~pin_sync[PIN_PB];
    assign kill_low = ~pin_sync[PIN_KILL];

    // free-running time base
    assign div_wrap     = (div_cnt == TICK_DIV - 1'b1);
    assign next_div_cnt = div_wrap ? '0 : div_cnt + 1'b1;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= div_wrap;
        end
    end

    // ext inputs are static straps, so they are used without a synchroniser
    assign ext = '{off_ext: OFF_DELAY_EXTEND_IN, kill_ext: KILL_DELAY_EXTEND_IN};

    // kill qualifier: level counted on the fast clock so 30 us is exact, not tick-quantised
    assign kq_done = (kq_cnt == KILL_QUAL - 1'b1);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            kq_cnt <= '0;
            kill_q <= 1'b0;
        end else if (!kill_low) begin
            kq_cnt <= '0;
            kill_q <= 1'b0;
        end else if (!kq_done) begin
            kq_cnt <= kq_cnt + 1'b1;
        end else begin
            kill_q <= 1'b1;
        end
    end

    // extensions add on top of the fixed intervals, never replace them
    assign off_lim  = pbs_pkg::OFF_DB_TICKS + pbs_pkg::CNT_W'(ext.off_ext);
    assign kill_lim = pbs_pkg::KILL_TICKS + pbs_pkg::CNT_W'(ext.kill_ext);

    wire tmr_hit_on   = tick && (tmr == pbs_pkg::ON_DB_TICKS - 1'b1);
    wire tmr_hit_bl   = tick && (tmr == pbs_pkg::BLANK_TICKS - 1'b1);
    wire tmr_hit_rel  = tick && (tmr == pbs_pkg::OFF_DB_TICKS - 1'b1);
    wire tmr_hit_off  = tick && (tmr == off_lim - 1'b1);
    wire tmr_hit_kill = tick && (tmr == kill_lim - 1'b1);
    wire tmr_hit_lock = tick && (tmr == pbs_pkg::LOCKOUT_TICKS - 1'b1);

    assign in_run_rel = (state == pbs_pkg::PBS_RUN_REL);
    assign in_run     = (state == pbs_pkg::PBS_RUN);

    // next state decode
    always_comb begin
        next_state = state;
        unique case (state)
            pbs_pkg::PBS_OFF: begin
                if (pb_low) begin
                    next_state = pbs_pkg::PBS_ON_DB;
                end
            end
            pbs_pkg::PBS_ON_DB: begin
                if (!pb_low) begin
                    next_state = pbs_pkg::PBS_OFF;
                end else if (tmr_hit_on) begin
                    next_state = pbs_pkg::PBS_BLANK;
                end
            end
            // blanking: neither pin is acted on until the timer ends
            pbs_pkg::PBS_BLANK: begin
                if (tmr_hit_bl && kill_low) begin
                    next_state = pbs_pkg::PBS_OFF;
                end else if (tmr_hit_bl) begin
                    next_state = pbs_pkg::PBS_RUN_REL;
                end
            end
            pbs_pkg::PBS_RUN_REL: begin
                if (kill_q) begin
                    next_state = pbs_pkg::PBS_LOCK;
                end else if (tmr_hit_rel) begin
                    next_state = pbs_pkg::PBS_RUN;
                end
            end
            pbs_pkg::PBS_RUN: begin
                if (kill_q) begin
                    next_state = pbs_pkg::PBS_LOCK;
                end else if (tmr_hit_off) begin
                    next_state = pbs_pkg::PBS_SHUT;
                end
            end
            // a qualified kill wins over a timeout landing in the same cycle
            pbs_pkg::PBS_SHUT: begin
                if (kill_q) begin
                    next_state = pbs_pkg::PBS_LOCK;
                end else if (tmr_hit_kill) begin
                    next_state = pbs_pkg::PBS_LOCK;
                end
            end
            pbs_pkg::PBS_LOCK: begin
                if (tmr_hit_lock) begin
                    next_state = pbs_pkg::PBS_OFF;
                end
            end
            default: begin
                next_state = pbs_pkg::PBS_OFF;
            end
        endcase
    end

    // timer restarts on every state change; in PBS_RUN_REL also on a press, in PBS_RUN also on release,
    // so a bouncing button never accumulates time across bounces
    assign pb_restart = (in_run_rel && pb_low) ||
                        (in_run && !pb_low);
    assign tmr_clear  = (next_state != state) || pb_restart;

    always_comb begin
        next_tmr = tmr;
        if (tmr_clear) begin
            next_tmr = '0;
        end else if (tick) begin
            next_tmr = tmr + 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state <= pbs_pkg::PBS_OFF;
            tmr   <= '0;
        end else begin
            state <= next_state;
            tmr   <= next_tmr;
        end
    end

    // shutdown after a button turn-off also goes through the 256 ms lockout, a safe superset
    assign on   = (next_state == pbs_pkg::PBS_BLANK) ||
                  (next_state == pbs_pkg::PBS_RUN_REL) ||
                  (next_state == pbs_pkg::PBS_RUN) ||
                  (next_state == pbs_pkg::PBS_SHUT);
    assign shut = (next_state == pbs_pkg::PBS_SHUT);

    // outputs are registered from the next state so the pins never show a decode glitch
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            POWER_ENABLE_OUT       <= ~EN_HIGH_TRUE;
            SHUTDOWN_REQUEST_N_OUT <= 1'b1;
        end else begin
            POWER_ENABLE_OUT       <= on ~^ EN_HIGH_TRUE;
            SHUTDOWN_REQUEST_N_OUT <= ~shut;
        end
    end
endmodule // pbs_seq
`default_nettype wire

//--- pbs_pkg.sv
// constants and types shared by the push button power sequencer
// Behaviour
// - If the kill input is still low when the 512 ms blanking ends, power enable is dropped.
// - After blanking, a qualified low on kill drops enable at once and cancels the kill timer.
// - After a qualified kill drops enable, the button is ignored for 256 ms before a new turn-on debounce; a kill at blanking end skips it.
// - A parameter picks high-true or low-true enable, with identical timing.
// - Turn-off needs the button low for 32 ms plus the configured off extension.
// - The kill timeout is 128 ms plus the configured kill extension, then enable drops.
// - Kill lows shorter than 30 us are ignored, except at blanking end, where any low drops enable.
// - A qualified kill low drops enable about 30 us after its falling edge.
// - Enable rises only after the button is held low 128 ms continuously; release restarts.
// - On enable a 512 ms blanking runs during which kill and the button are not sampled.
// - On turn-off debounce the shutdown request goes low and the kill timer starts.
package pbs_pkg;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned TICK_US       = 10;
    localparam int unsigned TICK_DIV      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned KILL_QUAL_US  = 30;
    localparam int unsigned KILL_QUAL_CYC = CLK_HZ / 1_000_000 * KILL_QUAL_US;
    localparam int unsigned ON_DB_MS      = 128;
    localparam int unsigned BLANK_MS      = 512;
    localparam int unsigned OFF_DB_MS     = 32;
    localparam int unsigned KILL_DLY_MS   = 128;
    localparam int unsigned LOCKOUT_MS    = 256;
    localparam int unsigned TICKS_PER_MS  = 1000 / TICK_US;
    localparam int unsigned CNT_W         = 24;
    localparam int unsigned EXT_W         = 16;
    localparam logic [CNT_W-1:0] ON_DB_TICKS   = CNT_W'(ON_DB_MS * TICKS_PER_MS);
    localparam logic [CNT_W-1:0] BLANK_TICKS   = CNT_W'(BLANK_MS * TICKS_PER_MS);
    localparam logic [CNT_W-1:0] OFF_DB_TICKS  = CNT_W'(OFF_DB_MS * TICKS_PER_MS);
    localparam logic [CNT_W-1:0] KILL_TICKS    = CNT_W'(KILL_DLY_MS * TICKS_PER_MS);
    localparam logic [CNT_W-1:0] LOCKOUT_TICKS = CNT_W'(LOCKOUT_MS * TICKS_PER_MS);

    typedef enum logic [2:0] {
        PBS_OFF,
        PBS_ON_DB,
        PBS_BLANK,
        PBS_RUN_REL,
        PBS_RUN,
        PBS_SHUT,
        PBS_LOCK
    } pbs_state_t;

    typedef struct packed {
        logic [EXT_W-1:0] off_ext;
        logic [EXT_W-1:0] kill_ext;
    } pbs_ext_t;
endpackage

//--- pbs_seq_properties.sv
// port assertions for the power sequencer
`timescale 1ns/1ps
`default_nettype none
module pbs_seq_properties #(
    parameter bit                        EN_HIGH_TRUE = 1'b1,
    parameter logic [pbs_pkg::CNT_W-1:0] TICK_DIV     = 24'h1,
    parameter logic [pbs_pkg::CNT_W-1:0] KILL_QUAL    = 24'h8
) (
    input wire logic                     CLK_IN,                 // clock
    input wire logic                     RST_IN,                 // reset
    input wire logic                     PUSH_BUTTON_N_IN,       // button
    input wire logic                     POWER_KILL_N_IN,        // kill
    input wire logic [pbs_pkg::EXT_W-1:0] OFF_DELAY_EXTEND_IN,   // off ext
    input wire logic [pbs_pkg::EXT_W-1:0] KILL_DELAY_EXTEND_IN,  // kill ext
    input wire logic                     POWER_ENABLE_OUT,       // enable
    input wire logic                     SHUTDOWN_REQUEST_N_OUT  // request
);
    localparam int TD  = int'(TICK_DIV);
    localparam int TPM = pbs_pkg::TICKS_PER_MS;
    localparam int KQ  = int'(KILL_QUAL);
    localparam int BT  = pbs_pkg::BLANK_MS * TPM * TD;
    localparam int AB  = 4 * TD + 10;
    wire logic en = POWER_ENABLE_OUT == EN_HIGH_TRUE;
    int pb_lo, kl_lo, on_cnt, sr_lo, off_cnt;
    // off_cnt starts large so the first turn-on is not taken for a lockout
    always_ff @(posedge CLK_IN) begin
        pb_lo   <= (RST_IN || PUSH_BUTTON_N_IN) ? 0 : pb_lo + 1;
        kl_lo   <= (RST_IN || POWER_KILL_N_IN) ? 0 : kl_lo + 1;
        on_cnt  <= (RST_IN || !en) ? 0 : on_cnt + 1;
        sr_lo   <= (RST_IN || SHUTDOWN_REQUEST_N_OUT) ? 0 : sr_lo + 1;
        off_cnt <= RST_IN ? 1 << 30 : (en ? 0 : off_cnt + 1);
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    AST_ON_DB: assert property ($rose(en) |-> pb_lo >= (pbs_pkg::ON_DB_MS * TPM - 1) * TD)
        else $error("enable rose before on debounce");
    AST_BLANK: assert property ($fell(en) |-> on_cnt >= BT - TD)
        else $error("enable dropped inside blanking");
    AST_ABORT: assert property (on_cnt == BT - TD - 4 && kl_lo > on_cnt |-> ##[0:AB] !en)
        else $error("power on not aborted");
    AST_QUAL: assert property ($fell(en) && $past(SHUTDOWN_REQUEST_N_OUT) |-> kl_lo >= KQ)
        else $error("short kill low dropped enable");
    AST_FAST: assert property (kl_lo == KQ + 2 && on_cnt > BT + KQ |-> ##[0:8] !en)
        else $error("kill did not drop enable");
    AST_OFF_DB: assert property ($fell(SHUTDOWN_REQUEST_N_OUT) |->
        pb_lo >= (pbs_pkg::OFF_DB_MS * TPM + OFF_DELAY_EXTEND_IN - 1) * TD)
        else $error("shutdown request before off debounce");
    AST_KILL_TO: assert property (sr_lo <=
        (pbs_pkg::KILL_DLY_MS * TPM + KILL_DELAY_EXTEND_IN + 2) * TD + 4)
        else $error("kill timeout overrun");
    AST_LOCK: assert property ($rose(en) |->
        off_cnt >= ((pbs_pkg::LOCKOUT_MS + pbs_pkg::ON_DB_MS) * TPM - 2) * TD)
        else $error("button taken during lockout");
endmodule // pbs_seq_properties
bind pbs_seq pbs_seq_properties #(.EN_HIGH_TRUE(EN_HIGH_TRUE), .TICK_DIV(TICK_DIV),
    .KILL_QUAL(KILL_QUAL)) i_pbs_seq_properties (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .PUSH_BUTTON_N_IN(PUSH_BUTTON_N_IN), .POWER_KILL_N_IN(POWER_KILL_N_IN),
    .OFF_DELAY_EXTEND_IN(OFF_DELAY_EXTEND_IN), .KILL_DELAY_EXTEND_IN(KILL_DELAY_EXTEND_IN),
    .POWER_ENABLE_OUT(POWER_ENABLE_OUT), .SHUTDOWN_REQUEST_N_OUT(SHUTDOWN_REQUEST_N_OUT));
`default_nettype wire

//--- pbs_host_model.sv
// host model: raises kill once powered, pulls it low after a shutdown request
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model (
    input  wire logic       clk_in,     // clock
    input  wire logic       en_in,      // system power on
    input  wire logic       sr_n_in,    // shutdown request
    input  wire logic       abort_in,   // host never comes up
    input  wire logic       glitch_in,  // short forced kill low
    input  wire logic [7:0] dly_in,     // answer delay in cycles
    output logic            kill_n_out  // kill pin
);
    logic      kill = 1'b0;
    int        cnt  = 0;
    wire logic goal = en_in && sr_n_in && !abort_in;
    always @(posedge clk_in) begin
        cnt <= (kill == goal) ? 0 : cnt + 1;
        if (kill != goal && cnt >= int'(dly_in))
            kill <= goal;
    end
    assign kill_n_out = kill & ~glitch_in;
endmodule // pbs_host_model
`default_nettype wire

//--- push_button_power_sequencer_bench.sv
// self-checking bench for the push button power sequencer
`timescale 1ns/1ps
`default_nettype none
module push_button_power_sequencer_bench;
    localparam int KQ = 8;
    logic clk = 1'b0, rst = 1'b1, pb = 1'b1, glitch = 1'b0, abort = 1'b0;
    logic [7:0] dly = 8'h20;
    pbs_pkg::pbs_ext_t ext = '0;
    logic kill_n, en_hi, en_lo, sr_n, sr2_n;
    int errors = 0, samples_checked = 0, n = 0, seed = 32'hd85a029e;
    pbs_seq #(.TICK_DIV(24'h1), .KILL_QUAL(24'h8)) i_pbs_seq (.CLK_IN(clk),
        .RST_IN(rst), .PUSH_BUTTON_N_IN(pb), .POWER_KILL_N_IN(kill_n), .OFF_DELAY_EXTEND_IN(ext.off_ext),
        .KILL_DELAY_EXTEND_IN(ext.kill_ext), .POWER_ENABLE_OUT(en_hi), .SHUTDOWN_REQUEST_N_OUT(sr_n));
    pbs_seq #(.EN_HIGH_TRUE(1'b0), .TICK_DIV(24'h1), .KILL_QUAL(24'h8)) i_pbs_seq_lo (.CLK_IN(clk),
        .RST_IN(rst), .PUSH_BUTTON_N_IN(pb), .POWER_KILL_N_IN(kill_n), .OFF_DELAY_EXTEND_IN(ext.off_ext),
        .KILL_DELAY_EXTEND_IN(ext.kill_ext), .POWER_ENABLE_OUT(en_lo), .SHUTDOWN_REQUEST_N_OUT(sr2_n));
    pbs_host_model i_pbs_host_model (.clk_in(clk), .en_in(en_hi), .sr_n_in(sr_n), .abort_in(abort),
        .glitch_in(glitch), .dly_in(dly), .kill_n_out(kill_n));
    function automatic int cyc(input int ms, input int ext_ticks);
        return ms * pbs_pkg::TICKS_PER_MS + ext_ticks;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp || en_lo !== ~en_hi || sr2_n !== sr_n) begin
            errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits at falling edges so the registered outputs have settled
    task automatic wait_on(input bit on_sr, input logic v, input int lim);
        n = 0;
        while ((on_sr ? sr_n : en_hi) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(on_sr ? sr_n : en_hi, v);
    endtask
    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (400000) @(posedge clk);
        errors++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clk);
        ext <= {16'($random(seed) & 255), 16'($random(seed) & 255)};
        dly <= 8'($random(seed) | 16);
        rst <= 1'b0;
        @(negedge clk) chk({en_hi, sr_n}, 2'b01);
        @(posedge clk) pb <= 1'b0;
        wait_on(1'b0, 1'b1, cyc(pbs_pkg::ON_DB_MS, 20));
        chk(n >= cyc(pbs_pkg::ON_DB_MS, -1), 1);
        @(posedge clk) pb <= 1'b1;
        repeat (cyc(pbs_pkg::BLANK_MS + pbs_pkg::OFF_DB_MS, 9)) @(posedge clk);
        glitch <= 1'b1;
        repeat (KQ - 4) @(posedge clk);
        glitch <= 1'b0;
        repeat (30) @(negedge clk);
        chk(en_hi, 1'b1);
        @(posedge clk) pb <= 1'b0;
        wait_on(1'b1, 1'b0, cyc(pbs_pkg::OFF_DB_MS, ext.off_ext + 20));
        chk(n >= cyc(pbs_pkg::OFF_DB_MS, ext.off_ext - 1), 1);
        wait_on(1'b0, 1'b0, dly + KQ + 40);
        chk(n >= dly + KQ, 1);
        @(posedge clk) pb <= 1'b1;
        repeat (10) @(posedge clk);
        pb <= 1'b0;
        abort <= 1'b1;
        wait_on(1'b0, 1'b1, cyc(pbs_pkg::LOCKOUT_MS + pbs_pkg::ON_DB_MS, 20));
        chk(n >= cyc(pbs_pkg::LOCKOUT_MS + pbs_pkg::ON_DB_MS, -2) - 11, 1);
        @(posedge clk) pb <= 1'b1;
        wait_on(1'b0, 1'b0, cyc(pbs_pkg::BLANK_MS, 20));
        chk(n >= cyc(pbs_pkg::BLANK_MS, -2), 1);
        test_done;
    end
endmodule // push_button_power_sequencer_bench
`default_nettype wire
